// [rtl/aphi_consts.svh]
// Offsets, field positions, reset values and counts of the parallel host port
`ifndef APHI_CONSTS_SVH
`define APHI_CONSTS_SVH

// ****************************************
// Bus offsets (byte addresses, low 8 bits)
// ****************************************
`define APHI_A_RESULT   8'h00
`define APHI_A_FLAGS    8'h04
`define APHI_A_SETTLE   8'h08
`define APHI_A_STATUS   8'h0c
`define APHI_A_PREG     8'h10
`define APHI_A_PREG_END 8'h2c

// ****************************************
// Port register file fields
// ****************************************
`define APHI_PREG_CNT   8
`define APHI_CTRL1_IDX  3'h0
`define APHI_CTRL2_IDX  3'h1
`define APHI_RB_EN_BIT  15
`define APHI_CLOCK_DIVIDE_SELECT_BIT   4

// ****************************************
// Reset values and counts
// ****************************************
`define APHI_PREG_RST   16'h0000
`define APHI_SETTLE_RST 16'h0040
`define APHI_SYNC_RST   20'h70000
`define APHI_SEQ_W      4

`endif

// [rtl/aphi_pkg.sv]
// Types shared by the parallel host port design
package aphi_pkg;

  // Conversion side flags written by the converter core
  typedef struct packed {
    logic over_range;
    logic user_filter_active;
    logic low_power_flag;
    logic filter_checksum_ok;
    logic lock_status;
  } aphi_flags_t;

  // Synchronised pin levels
  typedef struct packed {
    logic        master_clock_in;
    logic        read_write_n;
    logic        chip_select_n;
    logic        filter_align_n;
    logic [15:0] data;
  } aphi_pins_t;

  typedef enum logic [1:0] {
    P_IDLE,
    P_READ,
    P_WRITE
  } aphi_pstate_t;

endpackage

// [rtl/aphi_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module aphi_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // A bit moves only once the second and third stages agree
  always_comb begin
    q_nxt = (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
      q_r  <= RST;
    end else if (ce) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;

endmodule
`default_nettype wire

// [rtl/aphi_port.sv]
// Parallel host port of a sigma-delta converter with an AHB-Lite register side
//
// Function
// - Result read as two 16-bit words
// - New result gives one low ready pulse
// - First read drives upper sixteen result bits
// - Second read: low byte plus status
// - Status byte layout, low two bits zero
// - Bus released after select or direction rises
// - New result overwrites unread output register
// - Readback select returns chosen register next
// - Align sampled on falling master clock
// - Valid flag clear until filter settles
// - Register write is address then data
// - Read between writes clears pending address
// - Any register write restarts settle delay
// - Internal clock divide by one or two
// - Divider defaults to divide by two
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "aphi_consts.svh"
module aphi_port (
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Parallel port pins
  input  wire logic        master_clock_in,
  input  wire logic        read_write_n,
  input  wire logic        chip_select_n,
  input  wire logic        filter_align_n,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic             data_oe,
  output logic             result_ready_n
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  aphi_pkg::aphi_pins_t pins_raw;
  aphi_pkg::aphi_pins_t pins;

  assign pins_raw = '{master_clock_in, read_write_n, chip_select_n, filter_align_n, data_in};

  aphi_sync #(
    .W   (20),
    .RST (`APHI_SYNC_RST)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       (pins_raw),
    .q       (pins)
  );

  function automatic logic preg_hit(input logic [7:0] a);
    preg_hit = (a >= `APHI_A_PREG) && (a <= `APHI_A_PREG_END) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [2:0] preg_idx(input logic [7:0] a);
    logic [7:0] off;
    off      = a - `APHI_A_PREG;
    preg_idx = off[4:2];
  endfunction

  // ****************************************
  // Core state declarations
  // ****************************************
  aphi_pkg::aphi_pstate_t pstate_r, pstate_nxt;
  logic [23:0]              result_r, result_nxt;
  logic                     half_r, half_nxt;
  logic                     rdy_n_r, rdy_n_nxt;
  logic [15:0]              dout_r, dout_nxt;
  logic                     apend_r, apend_nxt;
  logic [2:0]               addr_r, addr_nxt;
  logic                     rbpend_r, rbpend_nxt;
  logic [2:0]               rbsel_r, rbsel_nxt;
  logic [15:0]              preg_r [`APHI_PREG_CNT];
  logic [15:0]              preg_nxt [`APHI_PREG_CNT];
  logic                     mclk_d_r, mclk_d_nxt;
  logic                     div_r, div_nxt;
  logic                     held_r, held_nxt;
  logic [`APHI_SEQ_W-1:0]   seq_r, seq_nxt;
  logic [15:0]              settle_r, settle_nxt;

  // ****************************************
  // Bus state declarations
  // ****************************************
  logic                     ap_wr_r, ap_wr_nxt;
  logic [7:0]               ap_addr_r, ap_addr_nxt;
  logic [31:0]              rdata_r, rdata_nxt;
  aphi_pkg::aphi_flags_t    flags_r, flags_nxt;
  logic [15:0]              settle_cfg_r, settle_cfg_nxt;

  logic                     res_wr;
  logic                     mclk_rise;
  logic                     mclk_fall;
  logic                     internal_clock_tick;
  logic                     clock_divide_select;
  logic                     result_valid;
  logic [7:0]               status_byte;
  logic                     port_wr_done;

  assign clock_divide_select         = preg_r[`APHI_CTRL2_IDX][`APHI_CLOCK_DIVIDE_SELECT_BIT];
  assign mclk_rise    = pins.master_clock_in & ~mclk_d_r;
  assign mclk_fall    = ~pins.master_clock_in & mclk_d_r;
  // Divide by one passes every rising edge, divide by two every other
  assign internal_clock_tick    = mclk_rise & (clock_divide_select | div_r);
  assign result_valid = (settle_r == 16'h0000) & ~held_r;
  assign status_byte  = {result_valid, flags_r.over_range, flags_r.user_filter_active,
                         flags_r.low_power_flag, flags_r.filter_checksum_ok,
                         flags_r.lock_status, 2'b00};
  assign res_wr       = ap_wr_r & (ap_addr_r == `APHI_A_RESULT);
  assign port_wr_done = (pstate_r == aphi_pkg::P_WRITE) & pins.chip_select_n;

  // ****************************************
  // Clock divider, align and settle
  // ****************************************
  always_comb begin
    mclk_d_nxt = pins.master_clock_in;
    div_nxt    = mclk_rise ? ~div_r : div_r;
    held_nxt   = held_r;
    seq_nxt    = seq_r;
    settle_nxt = settle_r;
    if (mclk_fall) begin
      held_nxt = ~pins.filter_align_n;
    end
    if (mclk_fall && !pins.filter_align_n) begin
      seq_nxt    = '0;
      settle_nxt = settle_cfg_r;
    end else if (port_wr_done && apend_r) begin
      settle_nxt = settle_cfg_r;
    end else if (internal_clock_tick && !held_r) begin
      seq_nxt = seq_r + 1'b1;
      if (settle_r != 16'h0000) begin
        settle_nxt = settle_r - 16'h0001;
      end
    end
  end

  // ****************************************
  // Port sequencing
  // ****************************************
  always_comb begin
    pstate_nxt = pstate_r;
    result_nxt = result_r;
    half_nxt   = half_r;
    rdy_n_nxt  = 1'b1;
    dout_nxt   = dout_r;
    apend_nxt  = apend_r;
    addr_nxt   = addr_r;
    rbpend_nxt = rbpend_r;
    rbsel_nxt  = rbsel_r;
    for (int i = 0; i < `APHI_PREG_CNT; i++) begin
      preg_nxt[i] = preg_r[i];
    end
    case (pstate_r)
      aphi_pkg::P_IDLE: begin
        if (!pins.chip_select_n && !pins.read_write_n) begin
          pstate_nxt = aphi_pkg::P_READ;
          if (rbpend_r) begin
            dout_nxt = preg_r[rbsel_r];
          end else if (half_r) begin
            dout_nxt = {result_r[7:0], status_byte};
          end else begin
            dout_nxt = result_r[23:8];
          end
        end else if (!pins.chip_select_n) begin
          pstate_nxt = aphi_pkg::P_WRITE;
        end
      end
      aphi_pkg::P_READ: begin
        if (pins.chip_select_n || pins.read_write_n) begin
          pstate_nxt = aphi_pkg::P_IDLE;
          apend_nxt  = 1'b0;
          if (rbpend_r) begin
            rbpend_nxt = 1'b0;
          end else begin
            half_nxt = ~half_r;
          end
        end
      end
      aphi_pkg::P_WRITE: begin
        // Word taken at the end of the strobe, when the bus has long settled
        if (pins.chip_select_n) begin
          pstate_nxt = aphi_pkg::P_IDLE;
          if (!apend_r) begin
            addr_nxt  = pins.data[2:0];
            apend_nxt = 1'b1;
          end else begin
            preg_nxt[addr_r] = pins.data;
            apend_nxt        = 1'b0;
            if (addr_r == `APHI_CTRL1_IDX) begin
              rbpend_nxt = pins.data[`APHI_RB_EN_BIT];
              rbsel_nxt  = pins.data[2:0];
            end
          end
        end
      end
      default: begin
        pstate_nxt = aphi_pkg::P_IDLE;
      end
    endcase
    // A new result replaces whatever the host has not yet read
    if (res_wr) begin
      result_nxt = hwdata[23:0];
      half_nxt   = 1'b0;
      rdy_n_nxt  = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pstate_r   <= aphi_pkg::P_IDLE;
      result_r   <= 24'h000000;
      half_r     <= 1'b0;
      rdy_n_r    <= 1'b1;
      dout_r     <= 16'h0000;
      apend_r    <= 1'b0;
      addr_r     <= 3'h0;
      rbpend_r   <= 1'b0;
      rbsel_r    <= 3'h0;
      mclk_d_r   <= 1'b0;
      div_r      <= 1'b0;
      held_r     <= 1'b0;
      seq_r      <= '0;
      settle_r   <= `APHI_SETTLE_RST;
      for (int i = 0; i < `APHI_PREG_CNT; i++) begin
        preg_r[i] <= `APHI_PREG_RST;
      end
    end else if (ce) begin
      pstate_r   <= pstate_nxt;
      result_r   <= result_nxt;
      half_r     <= half_nxt;
      rdy_n_r    <= rdy_n_nxt;
      dout_r     <= dout_nxt;
      apend_r    <= apend_nxt;
      addr_r     <= addr_nxt;
      rbpend_r   <= rbpend_nxt;
      rbsel_r    <= rbsel_nxt;
      mclk_d_r   <= mclk_d_nxt;
      div_r      <= div_nxt;
      held_r     <= held_nxt;
      seq_r      <= seq_nxt;
      settle_r   <= settle_nxt;
      for (int i = 0; i < `APHI_PREG_CNT; i++) begin
        preg_r[i] <= preg_nxt[i];
      end
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Read data is picked in the address phase so the answer needs no wait state
  always_comb begin
    ap_wr_nxt      = 1'b0;
    ap_addr_nxt    = ap_addr_r;
    rdata_nxt      = rdata_r;
    flags_nxt      = flags_r;
    settle_cfg_nxt = settle_cfg_r;
    if (ap_wr_r) begin
      case (ap_addr_r)
        `APHI_A_FLAGS:  flags_nxt      = hwdata[4:0];
        `APHI_A_SETTLE: settle_cfg_nxt = hwdata[15:0];
        default: begin
        end
      endcase
    end
    if (hready && hsel && htrans[1]) begin
      ap_wr_nxt   = hwrite;
      ap_addr_nxt = haddr[7:0];
      rdata_nxt   = 32'h00000000;
      if (!hwrite) begin
        if (preg_hit(haddr[7:0])) begin
          rdata_nxt = {16'h0000, preg_r[preg_idx(haddr[7:0])]};
        end else begin
          case (haddr[7:0])
            `APHI_A_RESULT: rdata_nxt = {8'h00, result_r};
            `APHI_A_FLAGS:  rdata_nxt = {27'h0, flags_r};
            `APHI_A_SETTLE: rdata_nxt = {16'h0000, settle_cfg_r};
            `APHI_A_STATUS: rdata_nxt = {20'h00000, seq_r, 2'b00, clock_divide_select, held_r,
                                         rbpend_r, apend_r, half_r, result_valid};
            default:        rdata_nxt = 32'h00000000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r      <= 1'b0;
      ap_addr_r    <= 8'h00;
      rdata_r      <= 32'h00000000;
      flags_r      <= '0;
      settle_cfg_r <= `APHI_SETTLE_RST;
    end else if (ce) begin
      ap_wr_r      <= ap_wr_nxt;
      ap_addr_r    <= ap_addr_nxt;
      rdata_r      <= rdata_nxt;
      flags_r      <= flags_nxt;
      settle_cfg_r <= settle_cfg_nxt;
    end
  end

  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = rdata_r;
  assign data_out       = dout_r;
  assign data_oe        = (pstate_r == aphi_pkg::P_READ);
  assign result_ready_n = rdy_n_r;

endmodule
`default_nettype wire

// [bench/aphi_port_asserts.sv]
// Concurrent checks on the parallel host port pins and ready pulse
`timescale 1ns/1ps
`default_nettype none
`include "aphi_consts.svh"
module aphi_port_asserts (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // Bus side
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  // Pins
  input  wire logic        read_write_n,
  input  wire logic        chip_select_n,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  input  wire logic        result_ready_n
);
  // ******************
  // Result write flag
  // ******************
  logic wr_res_r;
  logic wr_res_nxt;
  always_comb begin
    wr_res_nxt = hsel && hready && htrans[1] && hwrite && (haddr[7:0] == `APHI_A_RESULT);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_res_r <= 1'b0;
    end else if (ce) begin
      wr_res_r <= wr_res_nxt;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !ce);
  chk_pulse_cause: assert property (wr_res_r |=> !result_ready_n)
    else $error("no ready pulse after result write");
  chk_pulse_width: assert property ($fell(result_ready_n) |=> result_ready_n)
    else $error("ready pulse wider than one cycle");
  chk_pulse_only: assert property ($fell(result_ready_n) |-> $past(wr_res_r))
    else $error("ready pulse without a new result");
  chk_drive_read: assert property ((!chip_select_n && !read_write_n) [*8] |-> data_oe)
    else $error("bus not driven during read");
  chk_drive_cause: assert property ($rose(data_oe) |-> !chip_select_n && !read_write_n)
    else $error("bus driven without read");
  chk_bus_release: assert property (chip_select_n [*8] |-> !data_oe)
    else $error("bus held after deselect");
  chk_write_quiet: assert property (read_write_n [*8] |-> !data_oe)
    else $error("bus driven during write");
  chk_word_steady: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("driven word changed");
  cov_pulse: cover property ($fell(result_ready_n));
  cov_drive: cover property ($rose(data_oe));
  cov_release: cover property ($fell(data_oe));
endmodule
bind aphi_port aphi_port_asserts u_aphi_port_asserts (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
  .hready, .read_write_n, .chip_select_n, .data_out, .data_oe, .result_ready_n);
`default_nettype wire

// [bench/aphi_host.sv]
// Host controller model driving the parallel pins
`timescale 1ns/1ps
`default_nettype none
module aphi_host (
  // Clock
  input  wire logic        hclk,
  // Host driven pins
  output logic             master_clock_in,
  output logic             read_write_n,
  output logic             chip_select_n,
  output logic             filter_align_n,
  output logic      [15:0] data_in,
  // Device drive
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe
);
  // ****************
  // Pins and tasks
  // ****************
  logic [2:0]  mc = 3'h0;
  logic        hoe = 1'b0;
  logic        junk = 1'b0;
  logic [15:0] hd = 16'h0;
  initial begin
    master_clock_in = 1'b0;
    read_write_n = 1'b1;
    chip_select_n = 1'b1;
    filter_align_n = 1'b1;
  end
  // Master clock 20 MHz keeps the internal clock legal at both ratios
  always @(posedge hclk) begin
    junk <= ~junk;
    mc <= (mc == 3'h4) ? 3'h0 : mc + 3'h1;
    if (mc == 3'h4) begin
      master_clock_in <= ~master_clock_in;
    end
  end
  // Floating bus toggles so a stale word never looks valid
  assign data_in = data_oe ? data_out : hoe ? hd : {16{junk}};
  task rd(output logic ok);
    int k;
    repeat (45) @(posedge hclk);
    read_write_n <= 1'b0;
    chip_select_n <= 1'b0;
    k = 0;
    while (data_oe !== 1'b1 && k < 40) begin
      @(posedge hclk);
      k++;
    end
    ok = (k < 40);
    repeat (5) @(posedge hclk);
    read_write_n <= 1'b1;
    chip_select_n <= 1'b1;
  endtask
  task wr(input logic [15:0] d);
    repeat (90) @(posedge hclk);
    hd <= d;
    hoe <= 1'b1;
    chip_select_n <= 1'b0;
    repeat (90) @(posedge hclk);
    chip_select_n <= 1'b1;
    repeat (8) @(posedge hclk);
    hoe <= 1'b0;
  endtask
  task sync_lo;
    @(posedge master_clock_in);
    filter_align_n <= 1'b0;
    repeat (5) @(posedge master_clock_in);
  endtask
  task sync_hi;
    @(posedge master_clock_in);
    filter_align_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the parallel host port
`timescale 1ns/1ps
`default_nettype none
`include "aphi_consts.svh"
module tb_top;
  // ******************
  // Signals and tasks
  // ******************
  logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, ok;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        master_clock_in, read_write_n, chip_select_n, filter_align_n, data_oe, result_ready_n;
  logic [15:0] data_in, data_out;
  logic [23:0] res;
  logic [4:0]  fl;
  logic        rd_ph = 1'b0;
  logic        oe_d = 1'b0;
  logic [63:0] rq[$];
  logic [63:0] pq[$];
  int          n_fail = 0;
  int          tests_run = 0;
  aphi_port u_aphi_port (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .master_clock_in, .read_write_n, .chip_select_n,
    .filter_align_n, .data_in, .data_out, .data_oe, .result_ready_n);
  aphi_host u_aphi_host (.hclk, .master_clock_in, .read_write_n, .chip_select_n, .filter_align_n,
    .data_in, .data_out, .data_oe);
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Watchdog so a hung handshake still reaches the verdict
  initial begin
    repeat (20000) @(posedge hclk);
    tmo();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task results;
    n_fail += rq.size() + pq.size();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task tmo;
    n_fail++;
    $display("wrong value at %0t: timeout", $time);
    results();
  endtask
  task chk(input logic [31:0] g, input logic [63:0] n);
    tests_run++;
    if ((g & n[63:32]) !== n[31:0]) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, n[31:0]);
    end
  endtask
  task cmp_reg(input logic [31:0] g);
    chk(g, rq.size() ? rq.pop_front() : {32'hffffffff, 32'hx});
  endtask
  task cmp_word(input logic [15:0] g);
    chk({16'h0, g}, pq.size() ? pq.pop_front() : {32'hffffffff, 32'hx});
  endtask
  // Results appear on the data phase edge and on the drive rise
  always @(posedge hclk) begin
    if (rd_ph) cmp_reg(hrdata);
    if (data_oe && !oe_d) cmp_word(data_out);
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
    oe_d <= data_oe;
  end
  task wrdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) tmo();
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wrdy();
    htrans <= 2'b00;
    hwdata <= d;
    wrdy();
    hsel <= 1'b0;
  endtask
  task rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rq.push_back({m, e});
    ahb(1'b0, a, 32'h0);
  endtask
  task prd(input logic [15:0] m, input logic [15:0] e);
    pq.push_back({16'h0, m, 16'h0, e});
    u_aphi_host.rd(ok);
    if (!ok) tmo();
  endtask
  initial begin
    seed = 32'hc9dc6187;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    ce = 1'b1;
    hwdata = 32'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rreg(`APHI_A_STATUS, 32'h3f, 32'h0);
    rreg(`APHI_A_SETTLE, 32'hffff, 32'h40);
    rreg(8'h30, 32'hffffffff, 32'h0);
    ahb(1'b1, `APHI_A_SETTLE, 32'hc);
    $display("test reset values done");
    u_aphi_host.sync_lo();
    rreg(`APHI_A_STATUS, 32'hf10, 32'h10);
    u_aphi_host.sync_hi();
    for (int v = 0; v < 2; v++) begin
      seed = lfsr(seed);
      res = seed[23:0];
      fl = seed[28:24];
      ahb(1'b1, `APHI_A_FLAGS, {27'h0, fl});
      ahb(1'b1, `APHI_A_RESULT, {8'h0, ~res});
      ahb(1'b1, `APHI_A_RESULT, {8'h0, res});
      prd(16'hffff, res[23:8]);
      prd(16'hffff, {res[7:0], v[0], fl, 2'b00});
      repeat (400) @(posedge hclk);
    end
    $display("test result reads done");
    // Frozen slave must drop a write made while the enable is low
    @(posedge hclk);
    ce <= 1'b0;
    ahb(1'b1, `APHI_A_FLAGS, {27'h0, ~fl});
    @(posedge hclk);
    ce <= 1'b1;
    rreg(`APHI_A_FLAGS, 32'h1f, {27'h0, fl});
    $display("test clock enable done");
    u_aphi_host.wr(16'h1);
    u_aphi_host.wr(16'h10);
    rreg(`APHI_A_PREG + 8'h4, 32'hffff, 32'h10);
    rreg(`APHI_A_STATUS, 32'h20, 32'h20);
    u_aphi_host.wr(16'h0);
    u_aphi_host.wr(16'h8001);
    rreg(`APHI_A_STATUS, 32'h1, 32'h0);
    prd(16'hffff, 16'h10);
    $display("test readback done");
    u_aphi_host.wr(16'h2);
    prd(16'hffff, res[23:8]);
    u_aphi_host.wr(16'h1234);
    u_aphi_host.wr(16'hab);
    rreg(`APHI_A_PREG + 8'h8, 32'hffff, 32'h0);
    rreg(`APHI_A_PREG + 8'h10, 32'hffff, 32'hab);
    $display("test pending address done");
    repeat (5) @(posedge hclk);
    results();
  end
endmodule
`default_nettype wire
